//--- itm_defines.vh
// Register map, field positions and reset values for the interval timer block
`ifndef ITM_DEFINES_VH
`define ITM_DEFINES_VH
// Register offsets (byte addresses, 8-bit data on a plain port)
`define ITM_ADDR_W 4
`define ITM_OFS_MODE0 4'h0
`define ITM_OFS_RUN0 4'h1
`define ITM_OFS_OUT0 4'h2
`define ITM_OFS_CMP0 4'h3
`define ITM_OFS_MODE1 4'h4
`define ITM_OFS_RUN1 4'h5
`define ITM_OFS_OUT1 4'h6
`define ITM_OFS_CMP1 4'h7
`define ITM_OFS_IRQ_STAT 4'h8
`define ITM_OFS_IRQ_MASK 4'h9
`define ITM_OFS_COUNT0 4'hA
`define ITM_OFS_COUNT1 4'hB
// Mode control fields
`define ITM_FN_MSB 3
`define ITM_FN_LSB 0
`define ITM_CKS_MSB 6
`define ITM_CKS_LSB 4
`define ITM_MATCH_IRQ_ALLOW 7
`define ITM_FN_ONESHOT 4'h0
`define ITM_FN_CONTINUOUS 4'h1
// Run/irq control fields
`define ITM_RUN_BIT 7
`define ITM_IRQ_ALLOW 5
`define ITM_FLAG_BIT 2
// Shared output control fields
`define ITM_WAVE_BIT 6
// Reset values
`define ITM_RST_BYTE 8'h00
`define ITM_RST_CNT 8'h00
// Prescaler: count clock select 0..7 gives clk / 2^sel
`define ITM_PRESC_W 8
`endif

//--- itm_prescaler.v
// Free-running prescaler that makes the count clock enable pulses
`timescale 1ns/10ps
`include "itm_defines.vh"
module itm_prescaler #(
  parameter WIDTH = `ITM_PRESC_W
)
(
  input wire clk,
  input wire rst_n,
  output reg [WIDTH-1:0] taps
);
  // ***********************************************
  // Divider chain
  // ***********************************************
  reg [WIDTH-1:0] div;
  reg [WIDTH-1:0] div_prev;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div <= {WIDTH{1'b0}};
      div_prev <= {WIDTH{1'b0}};
      taps <= {WIDTH{1'b0}};
    end
    else
    begin
      div <= div + {{(WIDTH-1){1'b0}}, 1'b1};
      div_prev <= div;
      // Bit 0 of taps: every cycle; others: rising edge of divider bit
      taps <= {(div[WIDTH-2:0] & ~div_prev[WIDTH-2:0]), 1'b1};
    end
  end
endmodule // itm_prescaler

//--- itm_half.v
// One 8-bit interval timer half: counter, compare latch, wave output
`timescale 1ns/10ps
`include "itm_defines.vh"
module itm_half #(
  parameter CW = 8
)
(
  input wire clk,
  input wire rst_n,
  input wire tick,
  input wire [3:0] function_sel,
  input wire run_bit,
  input wire start,
  input wire [CW-1:0] compare_data,
  output reg [CW-1:0] count,
  output reg [CW-1:0] cmp_latch,
  output reg wave_out,
  output wire match,
  output wire stop_req
);
  wire continuous;
  wire counting;
  assign continuous = (function_sel == `ITM_FN_CONTINUOUS);
  assign counting = run_bit && !start;
  assign match = counting && tick && (count == cmp_latch);
  // One-shot clears its own run bit on match
  assign stop_req = match && !continuous;
  // ***********************************************
  // Counter and compare latch
  // ***********************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= `ITM_RST_CNT;
      cmp_latch <= `ITM_RST_CNT;
      wave_out <= 1'b0;
    end
    else
    begin
      if (start)
      begin
        count <= {CW{1'b0}};
        cmp_latch <= compare_data;
      end
      else if (match)
      begin
        wave_out <= ~wave_out;
        if (continuous)
        begin
          count <= {CW{1'b0}};
          cmp_latch <= compare_data;
        end
      end
      else if (counting && tick)
      begin
        count <= count + {{(CW-1){1'b0}}, 1'b1};
      end
      // Wave keeps its level when stopped
    end
  end
endmodule // itm_half

//--- itm_timer.v
// Two-channel 8-bit interval timer, one-shot and continuous modes
// Operation
// - function field 0000 one-shot, 0001 continuous
// - run write starts count from zero
// - match when count equals latched compare
// - one-shot match: toggle, flag, clear run
// - continuous match: toggle, flag, restart zero
// - one-shot latches compare only at start
// - continuous latches at start and match
// - output holds last level when stopped
`timescale 1ns/10ps
`include "itm_defines.vh"
module itm_timer #(
  parameter NCH = 2,
  parameter CW = 8
)
(
  input wire clk,
  input wire rst_n,
  input wire [`ITM_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  output wire [NCH-1:0] wave_out,
  output wire irq
);
  // ***********************************************
  // Register storage
  // ***********************************************
  reg [7:0] mode_ctl [0:NCH-1];
  reg [7:0] cmp_data [0:NCH-1];
  reg [NCH-1:0] run_bit;
  reg [NCH-1:0] irq_allow;
  reg [NCH-1:0] flag;
  reg [NCH-1:0] irq_mask;
  wire [`ITM_PRESC_W-1:0] taps;
  wire [NCH-1:0] match;
  wire [NCH-1:0] stop_req;
  wire [NCH-1:0] start;
  wire [CW-1:0] count [0:NCH-1];
  wire [CW-1:0] cmp_latch [0:NCH-1];

  function [3:0] ofs_of;
    input [1:0] kind;
    input integer ch;
    begin
      ofs_of = 4'h0;
      case (kind)
        2'h0: ofs_of = (ch == 0) ? `ITM_OFS_MODE0 : `ITM_OFS_MODE1;
        2'h1: ofs_of = (ch == 0) ? `ITM_OFS_RUN0 : `ITM_OFS_RUN1;
        2'h2: ofs_of = (ch == 0) ? `ITM_OFS_OUT0 : `ITM_OFS_OUT1;
        default: ofs_of = (ch == 0) ? `ITM_OFS_CMP0 : `ITM_OFS_CMP1;
      endcase
    end
  endfunction

  itm_prescaler #(
    .WIDTH(`ITM_PRESC_W)
  ) u_presc (
    .clk(clk),
    .rst_n(rst_n),
    .taps(taps)
  );

  // ***********************************************
  // Per-channel control
  // ***********************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      wire run_wr;
      wire tick;
      wire [3:0] fn;
      reg start_pend;
      assign fn = mode_ctl[g][`ITM_FN_MSB:`ITM_FN_LSB];
      assign tick = taps[mode_ctl[g][`ITM_CKS_MSB:`ITM_CKS_LSB]];
      assign run_wr = wr && (addr == ofs_of(2'h1, g));
      // Start is taken on the first tick after the run bit rises
      assign start[g] = start_pend && tick;
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          mode_ctl[g] <= `ITM_RST_BYTE;
          cmp_data[g] <= `ITM_RST_BYTE;
          run_bit[g] <= 1'b0;
          irq_allow[g] <= 1'b0;
          flag[g] <= 1'b0;
          start_pend <= 1'b0;
        end
        else
        begin
          if (wr && addr == ofs_of(2'h0, g))
          begin
            mode_ctl[g] <= wdata;
          end
          // leaves zero data to software; stored as written
          if (wr && addr == ofs_of(2'h3, g))
          begin
            cmp_data[g] <= wdata;
          end
          if (run_wr)
          begin
            irq_allow[g] <= wdata[`ITM_IRQ_ALLOW];
          end
          // Hardware stop wins over a same-cycle write
          if (stop_req[g])
          begin
            run_bit[g] <= 1'b0;
          end
          else if (run_wr)
          begin
            run_bit[g] <= wdata[`ITM_RUN_BIT];
          end
          if (stop_req[g])
          begin
            start_pend <= 1'b0;
          end
          else if (run_wr && wdata[`ITM_RUN_BIT] && !run_bit[g])
          begin
            start_pend <= 1'b1;
          end
          else if (start[g] || (run_wr && !wdata[`ITM_RUN_BIT]))
          begin
            start_pend <= 1'b0;
          end
          // Set wins over software clear of the flag
          if (match[g])
          begin
            flag[g] <= 1'b1;
          end
          else if (run_wr && !wdata[`ITM_FLAG_BIT])
          begin
            flag[g] <= 1'b0;
          end
          else if (wr && addr == `ITM_OFS_IRQ_STAT && wdata[g])
          begin
            flag[g] <= 1'b0;
          end
        end
      end
      itm_half #(
        .CW(CW)
      ) u_half (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .function_sel(fn),
        .run_bit(run_bit[g] && !start_pend),
        .start(start[g]),
        .compare_data(cmp_data[g][CW-1:0]),
        .count(count[g]),
        .cmp_latch(cmp_latch[g]),
        .wave_out(wave_out[g]),
        .match(match[g]),
        .stop_req(stop_req[g])
      );
    end
  endgenerate

  // ***********************************************
  // Interrupt
  // ***********************************************
  wire [NCH-1:0] allow;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_allow
      assign allow[g] = irq_allow[g] && mode_ctl[g][`ITM_MATCH_IRQ_ALLOW];
    end
  endgenerate
  assign irq = |(flag & irq_mask & allow);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_mask <= {NCH{1'b0}};
    end
    else if (wr && addr == `ITM_OFS_IRQ_MASK)
    begin
      irq_mask <= wdata[NCH-1:0];
    end
  end

  // ***********************************************
  // Read port, data one cycle after the strobe
  // ***********************************************
  reg [7:0] next_rdata;
  integer i;
  always @*
  begin
    next_rdata = 8'h00;
    for (i = 0; i < NCH; i = i + 1)
    begin
      if (addr == ofs_of(2'h0, i))
        next_rdata = mode_ctl[i];
      if (addr == ofs_of(2'h1, i))
      begin
        next_rdata[`ITM_RUN_BIT] = run_bit[i];
        next_rdata[`ITM_IRQ_ALLOW] = irq_allow[i];
        next_rdata[`ITM_FLAG_BIT] = flag[i];
      end
      if (addr == ofs_of(2'h2, i))
        next_rdata[`ITM_WAVE_BIT] = wave_out[i];
      if (addr == ofs_of(2'h3, i))
        next_rdata = cmp_data[i];
    end
    if (addr == `ITM_OFS_IRQ_STAT)
      next_rdata[NCH-1:0] = flag;
    if (addr == `ITM_OFS_IRQ_MASK)
      next_rdata[NCH-1:0] = irq_mask;
    if (addr == `ITM_OFS_COUNT0)
      next_rdata = count[0];
    if (addr == `ITM_OFS_COUNT1)
      next_rdata = count[1];
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= `ITM_RST_BYTE;
    end
    else if (rd)
    begin
      rdata <= next_rdata;
    end
    else
    begin
      rdata <= `ITM_RST_BYTE;
    end
  end
endmodule // itm_timer

//--- itm_timer_props.sv
// Port-level assertions for the two-channel interval timer
`timescale 1ns/10ps
`include "itm_defines.vh"
module itm_timer_props #(
  parameter NCH = 2,
  parameter CW = 8
)
(
  input wire clk,
  input wire rst_n,
  input wire [`ITM_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire [NCH-1:0] wave_out,
  input wire irq
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  out0_read_a: assert property (rd && addr == `ITM_OFS_OUT0 |=>
    rdata[`ITM_WAVE_BIT] == $past(wave_out[0])) else $error("channel 0 wave readback wrong");
  out1_read_a: assert property (rd && addr == `ITM_OFS_OUT1 |=>
    rdata[`ITM_WAVE_BIT] == $past(wave_out[1])) else $error("channel 1 wave readback wrong");
  unmapped_read_a: assert property (rd && addr > `ITM_OFS_COUNT1 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  irq_sticky_a: assert property (irq && !wr |=> irq)
    else $error("interrupt dropped without a write");
  irq_cause_a: assert property ($rose(irq) |-> $past(wr) || wave_out != $past(wave_out))
    else $error("interrupt rose without match or write");
  wave0_spacing_a: assert property ($changed(wave_out[0]) |=> $stable(wave_out[0]))
    else $error("channel 0 wave toggled twice in a row");
  wave1_spacing_a: assert property ($changed(wave_out[1]) |=> $stable(wave_out[1]))
    else $error("channel 1 wave toggled twice in a row");
endmodule // itm_timer_props

bind itm_timer itm_timer_props #(.NCH(NCH), .CW(CW)) props_u (.clk(clk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wave_out(wave_out), .irq(irq));

//--- itm_timer_test.sv
// Self-checking bench for the two-channel interval timer
`timescale 1ns/10ps
`include "itm_defines.vh"
module itm_timer_test;
  reg clk, rst_n, wr, rd;
  reg [3:0] addr;
  reg [7:0] wdata;
  wire [7:0] rdata;
  wire [1:0] wave_out;
  wire irq;
  integer bad_count, checks_done, n;
  itm_timer dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wave_out(wave_out), .irq(irq));
  // ****************************************
  // Bus and check helpers
  // ****************************************
  task check(input [7:0] seen, input [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task wr_reg(input [3:0] a, input [7:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
    #1;
  endtask
  task rd_chk(input [3:0] a, input [7:0] exp);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    check(rdata, exp);
  endtask
  // Bounded wait for a wave edge; n holds the cycles it took
  task wait_wave(input integer ch);
    reg old;
    old = wave_out[ch];
    n = 0;
    while (wave_out[ch] === old)
    begin
      @(posedge clk);
      #1;
      n = n + 1;
      if (n > 200)
      begin
        bad_count = bad_count + 1;
        complete_run;
      end
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task reset_values;
    integer a;
    for (a = 0; a < 16; a = a + 1)
      rd_chk(a[3:0], `ITM_RST_BYTE);
  endtask
  // Compare data rewritten mid-count must not shorten or stretch the shot
  task oneshot_ch0;
    wr_reg(`ITM_OFS_MODE0, 8'h80);
    wr_reg(`ITM_OFS_CMP0, 8'h05);
    wr_reg(`ITM_OFS_IRQ_MASK, 8'h01);
    wr_reg(`ITM_OFS_RUN0, 8'hA0);
    wr_reg(`ITM_OFS_CMP0, 8'h09);
    wait_wave(0);
    // Data 5 gives six ticks from start; one of them passes inside the data write
    check(n[7:0], 8'h05);
    rd_chk(`ITM_OFS_RUN0, 8'h24);
    rd_chk(`ITM_OFS_COUNT0, 8'h05);
    rd_chk(`ITM_OFS_OUT0, 8'h40);
    repeat (20) @(posedge clk);
    rd_chk(`ITM_OFS_OUT0, 8'h40);
    check({7'h00, irq}, 8'h01);
    rd_chk(`ITM_OFS_IRQ_STAT, 8'h01);
    wr_reg(`ITM_OFS_IRQ_STAT, 8'h01);
    check({7'h00, irq}, 8'h00);
  endtask
  // Count clock at half rate: period is 2 * (data + 1) cycles
  task continuous_ch1;
    wr_reg(`ITM_OFS_MODE1, 8'h91);
    wr_reg(`ITM_OFS_CMP1, 8'h03);
    wr_reg(`ITM_OFS_RUN1, 8'hA0);
    wait_wave(1);
    wr_reg(`ITM_OFS_CMP1, 8'h07);
    wait_wave(1);
    wait_wave(1);
    check(n[7:0], 8'h10);
    check({7'h00, irq}, 8'h00);
    wr_reg(`ITM_OFS_IRQ_MASK, 8'h02);
    check({7'h00, irq}, 8'h01);
    wr_reg(`ITM_OFS_RUN1, 8'h20);
    check({7'h00, irq}, 8'h00);
    repeat (40) @(posedge clk);
    rd_chk(`ITM_OFS_OUT1, 8'h40);
    // Two half-rate ticks after the last match, the second on the same edge as the stop
    rd_chk(`ITM_OFS_COUNT1, 8'h02);
  endtask
  // ****************************************
  // Clock, reset and sequence
  // ****************************************
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    rst_n = 1'h0;
    wr = 1'h0;
    rd = 1'h0;
    addr = 4'h0;
    wdata = 8'h00;
    bad_count = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    reset_values;
    oneshot_ch0;
    continuous_ch1;
    complete_run;
  end
endmodule // itm_timer_test
